// ### pkg/gpr_pkg.sv
// Constants and types shared by the port register block
package gpr_pkg;

    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    localparam int SIXTH_PORT = 6;
    localparam int HELD_LO = 4;
    localparam int HELD_N = 4;

    // Word indices inside one port's 16-byte slot
    localparam logic [1:0] REG_OUT = 2'h0;
    localparam logic [1:0] REG_FUNC = 2'h1;
    localparam logic [1:0] REG_DIR = 2'h2;
    localparam logic [1:0] REG_PIN = 2'h3;
    localparam int PORT_SHIFT = 4;
    localparam int REG_SHIFT = 2;
    localparam logic [23:0] MAP_HIGH = 24'h000000;

    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [7:0] RST_FUNC = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [31:0] RST_BUS = 32'h00000000;

    // Bit set where the pin is bonded out; index 6 leftmost
    localparam logic [NUM_PORTS-1:0][7:0] BONDED_DEF =
        {8'hF3, 8'h0D, 8'hFF, 8'hFF, 8'hD7, 8'h0F, 8'hFC};

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WR = 2'b01,
        PH_RD1 = 2'b10,
        PH_RD2 = 2'b11
    } gpr_phase_t;

endpackage : gpr_pkg

// ### rtl/gpr_port_regs.sv
// General-purpose port registers behind an AHB-Lite slave
`timescale 1ns/1ns
module gpr_port_regs #(
    parameter int NUM_PORTS = gpr_pkg::NUM_PORTS,
    parameter logic [gpr_pkg::NUM_PORTS-1:0][7:0] BONDED = gpr_pkg::BONDED_DEF
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [gpr_pkg::NUM_PORTS-1:0][7:0] pinIn,
    output logic [gpr_pkg::NUM_PORTS-1:0][7:0] pinOut,
    output logic [gpr_pkg::NUM_PORTS-1:0][7:0] pinOe,
    input wire logic [gpr_pkg::NUM_PORTS-1:0][7:0] periphOut,
    output logic [gpr_pkg::NUM_PORTS-1:0][7:0] periphIn
);

    if (NUM_PORTS != gpr_pkg::NUM_PORTS) begin : g_chk
        $error("NUM_PORTS must equal the package port count");
    end

    if (gpr_pkg::HELD_LO + gpr_pkg::HELD_N > gpr_pkg::PORT_W) begin : g_held_chk
        $error("held bits must fit in one port byte");
    end

    typedef logic [gpr_pkg::NUM_PORTS-1:0][7:0] gpr_bank_t;

    typedef struct packed {
        gpr_pkg::gpr_phase_t phase;
        logic [7:0] addr;
        logic mapped;
        gpr_bank_t outVal;
        gpr_bank_t func;
        gpr_bank_t dir;
        logic [gpr_pkg::HELD_N-1:0] held;
        logic [gpr_pkg::HELD_N-1:0] pend;
        logic [31:0] rdData;
        logic [31:0] lastBus;
    } gpr_state_t;

    gpr_state_t st_ff;
    gpr_state_t nxt_st;
    gpr_bank_t pinLevel;
    logic [2:0] wrPort;
    logic [1:0] wrReg;
    logic [7:0] wrByte;
    logic takeReq;
    logic [7:0] holdMask;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic addr_mapped(input logic [31:0] a);
        addr_mapped = (a[31:8] == gpr_pkg::MAP_HIGH) && (a[1:0] == 2'h0)
            && (32'(a[7:gpr_pkg::PORT_SHIFT]) < 32'(gpr_pkg::NUM_PORTS));
    endfunction : addr_mapped

    function automatic logic [31:0] read_word(
        input gpr_state_t s,
        input gpr_bank_t lvl
    );
        logic [2:0] p;
        logic [7:0] b;
        p = s.addr[6:gpr_pkg::PORT_SHIFT];
        case (s.addr[3:gpr_pkg::REG_SHIFT])
            gpr_pkg::REG_OUT: b = s.outVal[p];
            gpr_pkg::REG_FUNC: b = s.func[p];
            gpr_pkg::REG_DIR: b = s.dir[p];
            default: b = lvl[p];
        endcase
        // Reserved lanes echo the last bus word; nothing pulls them to a constant
        if (s.mapped) begin
            read_word = {s.lastBus[31:8], b};
        end else begin
            read_word = s.lastBus;
        end
    endfunction : read_word

    function automatic logic [7:0] hold_mask(input gpr_bank_t f, input logic [2:0] port);
        hold_mask = 8'h00;
        if (32'(port) == gpr_pkg::SIXTH_PORT) begin
            for (int h = 0; h < gpr_pkg::HELD_N; h++) begin
                hold_mask[gpr_pkg::HELD_LO+h] = f[gpr_pkg::SIXTH_PORT][gpr_pkg::HELD_LO+h];
            end
        end
    endfunction : hold_mask

    ////////////////////////////////////////////////////////////////////////////////
    // Pin side

    always_comb begin
        logic drv;
        drv = 1'b0;
        for (int p = 0; p < gpr_pkg::NUM_PORTS; p++) begin
            for (int b = 0; b < gpr_pkg::PORT_W; b++) begin
                drv = st_ff.func[p][b] ? periphOut[p][b] : st_ff.outVal[p][b];
                // Open drain when direction is set: drive low only
                pinOut[p][b] = drv & ~st_ff.dir[p][b];
                pinOe[p][b] = BONDED[p][b] & (~st_ff.dir[p][b] | ~drv);
                // No pin: the data bit is the level seen inside
                pinLevel[p][b] = BONDED[p][b] ? pinIn[p][b] : st_ff.outVal[p][b];
            end
        end
    end

    assign periphIn = pinLevel;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and register state

    assign hreadyout = (st_ff.phase != gpr_pkg::PH_RD1);
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdData;
    assign takeReq = hsel && htrans[1] && hready;
    assign wrPort = st_ff.addr[6:gpr_pkg::PORT_SHIFT];
    assign wrReg = st_ff.addr[3:gpr_pkg::REG_SHIFT];
    assign wrByte = hwdata[7:0];
    assign holdMask = hold_mask(st_ff.func, wrPort);

    always_comb begin
        nxt_st = st_ff;
        case (st_ff.phase)
            gpr_pkg::PH_WR: begin
                nxt_st.lastBus = hwdata;
                if (st_ff.mapped) begin
                    case (wrReg)
                        gpr_pkg::REG_OUT: begin
                            // Port 6 bits 4 to 7 still owned by their function keep the old value
                            nxt_st.outVal[wrPort] = (wrByte & ~holdMask)
                                | (st_ff.outVal[wrPort] & holdMask);
                            for (int h = 0; h < gpr_pkg::HELD_N; h++) begin
                                if (holdMask[gpr_pkg::HELD_LO+h]) begin
                                    nxt_st.held[h] = wrByte[gpr_pkg::HELD_LO+h];
                                    nxt_st.pend[h] = 1'b1;
                                end
                            end
                        end
                        gpr_pkg::REG_FUNC: nxt_st.func[wrPort] = wrByte;
                        gpr_pkg::REG_DIR: nxt_st.dir[wrPort] = wrByte;
                        default: ;
                    endcase
                end
            end
            gpr_pkg::PH_RD1: begin
                nxt_st.rdData = read_word(st_ff, pinLevel);
                nxt_st.lastBus = read_word(st_ff, pinLevel);
                nxt_st.phase = gpr_pkg::PH_RD2;
            end
            default: ;
        endcase
        // Held value lands the moment its function bit is zero
        for (int h = 0; h < gpr_pkg::HELD_N; h++) begin
            if (st_ff.pend[h] && !nxt_st.func[gpr_pkg::SIXTH_PORT][gpr_pkg::HELD_LO+h]) begin
                nxt_st.outVal[gpr_pkg::SIXTH_PORT][gpr_pkg::HELD_LO+h] = st_ff.held[h];
                nxt_st.pend[h] = 1'b0;
            end
        end
        if (st_ff.phase != gpr_pkg::PH_RD1) begin
            nxt_st.phase = gpr_pkg::PH_IDLE;
            if (takeReq) begin
                nxt_st.phase = hwrite ? gpr_pkg::PH_WR : gpr_pkg::PH_RD1;
                nxt_st.addr = haddr[7:0];
                nxt_st.mapped = addr_mapped(haddr);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_ff.phase <= gpr_pkg::PH_IDLE;
            st_ff.addr <= 8'h00;
            st_ff.mapped <= 1'b0;
            st_ff.outVal <= {gpr_pkg::NUM_PORTS{gpr_pkg::RST_OUT}};
            st_ff.func <= {gpr_pkg::NUM_PORTS{gpr_pkg::RST_FUNC}};
            st_ff.dir <= {gpr_pkg::NUM_PORTS{gpr_pkg::RST_DIR}};
            st_ff.held <= 4'h0;
            st_ff.pend <= 4'h0;
            st_ff.rdData <= gpr_pkg::RST_BUS;
            st_ff.lastBus <= gpr_pkg::RST_BUS;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    store_out_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR && st_ff.mapped && st_ff.addr == 8'h00
        |=> st_ff.outVal[0] == $past(hwdata[7:0]))
    else $error("port 0 data write not stored");

    push_pull_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        BONDED[3][0] && !st_ff.dir[3][0] |-> pinOe[3][0] && pinOut[3][0] ==
        (st_ff.func[3][0] ? periphOut[3][0] : st_ff.outVal[3][0]))
    else $error("push-pull output not driven");

    port_route_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !st_ff.func[3][1] && !st_ff.dir[3][1] |-> pinOut[3][1] == st_ff.outVal[3][1])
    else $error("port function not routed to pin");

    tie_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !BONDED[0][0] |-> periphIn[0][0] == st_ff.outVal[0][0] && !pinOe[0][0])
    else $error("pinless bit not tied to data");

    held_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR && st_ff.mapped && st_ff.addr == 8'h60
        && st_ff.func[6][4] |=> st_ff.outVal[6][4] == $past(st_ff.outVal[6][4])
        && st_ff.held[0] == $past(hwdata[4]) && st_ff.pend[0])
    else $error("port 6 bit 4 write not held");

    read_reg_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_RD1 && st_ff.mapped && st_ff.addr == 8'h60
        |=> hrdata[7:4] == $past(st_ff.outVal[6][7:4]))
    else $error("port 6 read shows held value");

    reserved_bits_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_RD1 |=> hrdata[31:8] == $past(st_ff.lastBus[31:8])
        && !$past(hreadyout) && hreadyout)
    else $error("reserved bits not last bus value");

    held_land_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(st_ff.pend[1]) && $fell(st_ff.func[6][5])
        |-> st_ff.outVal[6][5] == $past(st_ff.held[1]) && !st_ff.pend[1])
    else $error("held bit not loaded on clear");

    pinless_store_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR && st_ff.mapped && st_ff.addr == 8'h10
        |=> st_ff.outVal[1][7:4] == $past(hwdata[7:4]))
    else $error("pinless data bits not stored");

    func_store_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR && st_ff.mapped
        && st_ff.addr[3:2] == gpr_pkg::REG_FUNC
        |=> st_ff.func[$past(st_ff.addr[6:4])] == $past(hwdata[7:0]))
    else $error("function select write not stored");

    dir_store_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR && st_ff.mapped
        && st_ff.addr[3:2] == gpr_pkg::REG_DIR
        |=> st_ff.dir[$past(st_ff.addr[6:4])] == $past(hwdata[7:0]))
    else $error("direction select write not stored");

    write_ready_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR |-> hreadyout && !hresp)
    else $error("write data phase stalled");

    open_drain_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (pinOut & st_ff.dir) == '0)
    else $error("pin driven high while open drain");

    periph_route_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.func[3][2] && !st_ff.dir[3][2] |-> pinOut[3][2] == periphOut[3][2])
    else $error("peripheral drive not routed to pin");

    pinless_oe_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (pinOe & ~BONDED) == '0 && (periphIn & ~BONDED) == (st_ff.outVal & ~BONDED))
    else $error("pinless bit reached a pin");

    bonded_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (periphIn & BONDED) == (pinIn & BONDED))
    else $error("bonded pin level not passed inside");

    direct_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR && st_ff.mapped && st_ff.addr == 8'h60
        && !st_ff.func[6][7] |=> st_ff.outVal[6][7] == $past(hwdata[7]))
    else $error("port 6 bit 7 write did not pass through");

    pend_owned_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.pend[3] |-> st_ff.func[6][7])
    else $error("held bit pending after function cleared");

    read_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_RD1 |-> !hreadyout ##1 hreadyout)
    else $error("read wait state missing");

    echo_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR |=> st_ff.lastBus == $past(hwdata))
    else $error("written word not kept as last bus value");

    unmapped_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_RD1 && !st_ff.mapped
        |=> hrdata == $past(st_ff.lastBus) && st_ff.lastBus == hrdata)
    else $error("unmapped read not last bus value");

    held_only_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(st_ff.phase == gpr_pkg::PH_WR && st_ff.mapped && st_ff.addr == 8'h60)
        |=> $stable(st_ff.held))
    else $error("held bits changed without a port 6 write");

    held_replace_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_ff.phase == gpr_pkg::PH_WR && st_ff.mapped && st_ff.addr == 8'h60
        && st_ff.func[6][6] |=> st_ff.held[2] == $past(hwdata[6]) && st_ff.pend[2])
    else $error("later write did not replace held bit");

endmodule : gpr_port_regs

// ### tb/port_pin_register_behaviour_test.sv
// Self-checking bench for the port register block
`timescale 1ns/1ns
module port_pin_register_behaviour_test;
    logic clk_sys, rstn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, seed, w;
    logic [6:0][7:0] pinIn, pinOut, pinOe, periphOut, periphIn;
    logic [7:0] b, d, f, r, drv;
    int failures = 0;
    int num_checks = 0;

    gpr_port_regs dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .periphOut(periphOut),
        .periphIn(periphIn));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] ad(input int p, input int k);
        return 32'(p * 16 + k * 4);
    endfunction : ad

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One single transfer; waits on hready, so no latency is assumed
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (wr) hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
        check("hresp", 32'(hresp), 32'h00000000);
    endtask : bus

    // Pin side; pinless bits only matter inside the chip
    task automatic pins(input int p);
        @(negedge clk_sys);
        b = gpr_pkg::BONDED_DEF[p];
        drv = (f & periphOut[p]) | (~f & d);
        check("pinOe", 32'(pinOe[p]), 32'(b & ~(r & drv)));
        check("pinOut", 32'(pinOut[p] & b), 32'(b & ~r & drv));
        check("periphIn", 32'(periphIn[p]), 32'((pinIn[p] & b) | (d & ~b)));
    endtask : pins

    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        finish_test();
    end

    initial begin
        seed = 32'h00000E2F;
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        pinIn = '0;
        periphOut = '0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        bus(1'b0, ad(2, 2), 32'h00000000);
        check("dirReset", rd, {gpr_pkg::RST_BUS[31:8], gpr_pkg::RST_DIR});
        for (int p = 0; p < 7; p++) begin
            pinIn <= 56'({rnd(), rnd()});
            periphOut <= 56'({rnd(), rnd()});
            w = rnd();
            d = w[7:0];
            r = w[23:16];
            f = 8'h00;
            bus(1'b1, ad(p, 2), {w[31:8], r});
            bus(1'b1, ad(p, 1), {w[31:8], f});
            bus(1'b1, ad(p, 0), {w[31:8], d});
            pins(p);
            f = w[15:8];
            bus(1'b1, ad(p, 1), {w[31:8], f});
            pins(p);
            bus(1'b0, ad(p, 0), 32'h00000000);
            check("data", rd, {w[31:8], d});
            bus(1'b0, ad(p, 1), 32'h00000000);
            check("func", rd, {w[31:8], f});
            bus(1'b0, ad(p, 2), 32'h00000000);
            check("dir", rd, {w[31:8], r});
            bus(1'b0, ad(p, 3), 32'h00000000);
            check("pinLevel", rd, {w[31:8], (pinIn[p] & b) | (d & ~b)});
        end
        // Upper half of port 6 held while its function bits are set
        w = rnd();
        bus(1'b1, ad(6, 1), {w[31:8], 8'h00});
        bus(1'b1, ad(6, 0), {w[31:8], 8'hA0});
        bus(1'b1, ad(6, 1), {w[31:8], 8'hF0});
        bus(1'b1, ad(6, 0), {w[31:8], 8'h5F});
        bus(1'b0, ad(6, 0), 32'h00000000);
        check("heldHidden", rd, {w[31:8], 8'hAF});
        bus(1'b1, ad(6, 0), {w[31:8], 8'h3F});
        bus(1'b1, ad(6, 1), {w[31:8], 8'hE0});
        bus(1'b0, ad(6, 0), 32'h00000000);
        check("heldBit4", rd, {w[31:8], 8'hBF});
        bus(1'b1, ad(6, 1), {w[31:8], 8'h00});
        bus(1'b0, ad(6, 0), 32'h00000000);
        check("heldAll", rd, {w[31:8], 8'h3F});
        // Unmapped words show the last bus value
        w = rnd();
        bus(1'b1, ad(0, 0), w);
        bus(1'b0, 32'h00000100, 32'h00000000);
        check("unmapped", rd, w);
        bus(1'b0, ad(7, 0), 32'h00000000);
        check("noPort", rd, w);
        finish_test();
    end
endmodule : port_pin_register_behaviour_test
